/* design/iam_accept.sv */
`timescale 1ns/100ps
module iam_accept
  import iam_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic standby,
  input wire logic nmi_pin,
  input wire logic [NUM_SRC-1:0] ext_req_pin,
  input wire logic [NUM_SRC-1:0] mod_req,
  input wire logic [NUM_SRC-1:0] req_enable,
  input wire iam_cfg_t cfg,
  input wire iam_flags_t flags_in,
  input wire logic insn_done,
  input wire logic [15:0] program_counter,
  input wire logic [7:0] condition_code_reg,
  input wire logic push_done,
  output logic irq_take,
  output logic push_req,
  output logic [15:0] push_pc,
  output logic [7:0] push_ccr,
  output logic flags_wr,
  output iam_flags_t flags_out,
  output logic vec_valid,
  output logic [15:0] vec_addr,
  output logic [7:0] vec_num,
  output logic [NUM_SRC-1:0] pending
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [NUM_SRC-1:0] ext_s1_r;
  logic [NUM_SRC-1:0] ext_s2_r;
  logic nmi_s1_r;
  logic nmi_s2_r;
  logic nmi_d_r;
  logic nmi_latch_r;
  // external lines pass two flops before anything reads them
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ext_s1_r <= '0;
      ext_s2_r <= '0;
      nmi_s1_r <= 1'b0;
      nmi_s2_r <= 1'b0;
      nmi_d_r <= 1'b0;
    end else begin
      ext_s1_r <= ext_req_pin;
      ext_s2_r <= ext_s1_r;
      nmi_s1_r <= nmi_pin;
      nmi_s2_r <= nmi_s1_r;
      nmi_d_r <= nmi_s2_r;
    end
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  iam_state_t state_r;
  iam_state_t state_nxt;
  logic take_nmi_r;
  logic [4:0] take_idx_r;
  logic irq_take_r;
  logic push_req_r;
  logic [15:0] push_pc_r;
  logic [7:0] push_ccr_r;
  logic flags_wr_r;
  iam_flags_t flags_out_r;
  logic vec_valid_r;
  logic [15:0] vec_addr_r;
  logic [7:0] vec_num_r;
  logic [NUM_SRC-1:0] pending_r;

  // ---------------------------------------------------------------
  // mask decode
  // ---------------------------------------------------------------
  wire logic nmi_edge = nmi_s2_r & ~nmi_d_r;
  wire logic [NUM_GRP-1:0] prio_bits = {cfg.prio_a, cfg.prio_b};
  wire logic [NUM_SRC-1:0] all_req = ext_s2_r | mod_req;
  // scheme 1 ignores the second flag and levels only order requests
  wire logic allow_lvl0 = ~flags_in.global_mask;
  wire logic allow_lvl1 = cfg.scheme_sel ? ~flags_in.global_mask
                                         : ~(flags_in.global_mask & flags_in.second_mask);
  wire logic sel_found;
  wire logic [4:0] sel_idx;
  wire logic [NUM_SRC-1:0] live_mask = all_req & req_enable;

  iam_select u_select (
    .req(all_req),
    .enable(req_enable),
    .prio_bits(prio_bits),
    .allowed_lvl0({NUM_SRC{1'b1}}),
    .allow_lvl1(allow_lvl1),
    .allow_lvl0(allow_lvl0),
    .found(sel_found),
    .idx(sel_idx)
  );

  // nmi wins over any maskable source and ignores both flags
  wire logic want_nmi = nmi_latch_r & ~standby;
  wire logic want_any = want_nmi | sel_found;
  wire logic boundary = insn_done & (state_r == IAM_IDLE);

  wire logic [7:0] vnum;
  wire logic [15:0] vaddr;
  iam_vector u_vector (
    .is_nmi(take_nmi_r),
    .idx(take_idx_r),
    .vec_num(vnum),
    .vec_addr(vaddr)
  );

  // ---------------------------------------------------------------
  // handling sequence
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      IAM_IDLE: begin
        if (boundary && want_any) begin
          state_nxt = IAM_PUSH;
        end
      end
      IAM_WAIT_INSN: state_nxt = IAM_PUSH;
      IAM_PUSH: begin
        if (push_done) begin
          state_nxt = IAM_SET_MASK;
        end
      end
      IAM_SET_MASK: state_nxt = IAM_VECTOR;
      IAM_VECTOR: state_nxt = IAM_IDLE;
    endcase
  end

  // nmi latch: set wins over the clear when both fall in one cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      nmi_latch_r <= 1'b0;
    end else if (nmi_edge && !standby) begin
      nmi_latch_r <= 1'b1;
    end else if (boundary && want_nmi) begin
      nmi_latch_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_r <= IAM_IDLE;
      take_nmi_r <= 1'b0;
      take_idx_r <= 5'h00;
    end else begin
      state_r <= state_nxt;
      if (boundary && want_any) begin
        take_nmi_r <= want_nmi;
        take_idx_r <= sel_idx;
      end
    end
  end

  // capture core state for the push; pc is the resume address
  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_take_r <= 1'b0;
      push_req_r <= 1'b0;
      push_pc_r <= 16'h0000;
      push_ccr_r <= 8'h00;
    end else begin
      irq_take_r <= boundary && want_any;
      push_req_r <= (state_nxt == IAM_PUSH);
      if (boundary && want_any) begin
        push_pc_r <= program_counter;
        push_ccr_r <= condition_code_reg;
      end
    end
  end

  // mask update after the push
  always_ff @(posedge core_clk) begin
    if (rst) begin
      flags_wr_r <= 1'b0;
      flags_out_r <= '0;
    end else begin
      flags_wr_r <= (state_r == IAM_SET_MASK);
      if (state_r == IAM_SET_MASK) begin
        flags_out_r.global_mask <= 1'b1;
        flags_out_r.second_mask <= cfg.scheme_sel ? flags_in.second_mask : 1'b1;
      end
    end
  end

  // vector out, and pending view of everything left waiting
  always_ff @(posedge core_clk) begin
    if (rst) begin
      vec_valid_r <= 1'b0;
      vec_addr_r <= 16'h0000;
      vec_num_r <= 8'h00;
      pending_r <= '0;
    end else begin
      vec_valid_r <= (state_r == IAM_VECTOR);
      if (state_r == IAM_VECTOR) begin
        vec_addr_r <= vaddr;
        vec_num_r <= vnum;
      end
      pending_r <= live_mask;
    end
  end

  assign irq_take = irq_take_r;
  assign push_req = push_req_r;
  assign push_pc = push_pc_r;
  assign push_ccr = push_ccr_r;
  assign flags_wr = flags_wr_r;
  assign flags_out = flags_out_r;
  assign vec_valid = vec_valid_r;
  assign vec_addr = vec_addr_r;
  assign vec_num = vec_num_r;
  assign pending = pending_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // helper views for the selection checks; spare entries are dropped so
  // that a stray spare request cannot make an antecedent true, except in chk_open_accept, which reads live_mask
  wire logic [NUM_SRC-1:0] lvl1_map;
  wire logic [NUM_SRC-1:0] used_map;
  wire logic [NUM_SRC-1:0] below_sel;
  wire logic [NUM_SRC-1:0] same_lvl;
  genvar c;
  generate
    for (c = 0; c < NUM_SRC; c++) begin : g_chk
      assign lvl1_map[c] = prio_bits[SRC_GRP[c]];
      assign used_map[c] = (c < SRC_USED);
      assign below_sel[c] = (5'(c) < sel_idx);
      assign same_lvl[c] = (lvl1_map[c] == lvl1_map[sel_idx]);
    end
  endgenerate
  wire logic [NUM_SRC-1:0] live_used = live_mask & used_map;
  wire logic any_lvl1 = |(live_used & lvl1_map);

  sequence s_take;
    boundary && want_any;
  endsequence
  sequence s_push_to_vec;
    (state_r == IAM_SET_MASK) ##1 (state_r == IAM_VECTOR) ##1 vec_valid_r;
  endsequence

  chk_take_boundary: assert property (@(posedge core_clk) disable iff (rst)
    $rose(irq_take_r) |-> $past(insn_done))
    else $error("accept outside an instruction boundary");
  chk_take_pulse: assert property (@(posedge core_clk) disable iff (rst)
    s_take |=> irq_take_r ##1 push_req_r)
    else $error("accept did not start the push");
  chk_push_seq: assert property (@(posedge core_clk) disable iff (rst)
    (state_r == IAM_PUSH && push_done) |=> s_push_to_vec)
    else $error("push not followed by mask and vector");
  chk_mask_global: assert property (@(posedge core_clk) disable iff (rst)
    (state_r == IAM_SET_MASK) |=> flags_wr_r && flags_out_r.global_mask)
    else $error("global mask not set");
  chk_mask_both: assert property (@(posedge core_clk) disable iff (rst)
    (state_r == IAM_SET_MASK && !cfg.scheme_sel) |=> flags_out_r.second_mask)
    else $error("second mask not set");
  chk_masked_all: assert property (@(posedge core_clk) disable iff (rst)
    (boundary && flags_in.global_mask && (cfg.scheme_sel || flags_in.second_mask) && !want_nmi)
      |=> !irq_take_r)
    else $error("maskable request accepted while masked");
  chk_lvl0_held: assert property (@(posedge core_clk) disable iff (rst)
    (flags_in.global_mask && sel_found) |-> prio_bits[SRC_GRP[sel_idx]])
    else $error("level 0 request passed the mask");
  chk_open_accept: assert property (@(posedge core_clk) disable iff (rst)
    (boundary && !flags_in.global_mask && (|live_mask)) |=> irq_take_r)
    else $error("unmasked request not accepted");
  chk_nmi_wins: assert property (@(posedge core_clk) disable iff (rst)
    (boundary && want_nmi) |=> take_nmi_r)
    else $error("nmi not chosen");
  chk_vec_addr: assert property (@(posedge core_clk) disable iff (rst)
    $rose(vec_valid_r) |-> vec_addr_r == {6'h00, vec_num_r, 2'b00})
    else $error("vector address mismatch");

  // ---------------------------------------------------------------
  // acceptance, capture, selection and masking checks
  // ---------------------------------------------------------------
  // state handed to the push must be what the core showed at the accept
  sequence s_capture;
    push_req_r && (push_pc_r == $past(program_counter)) && (push_ccr_r == $past(condition_code_reg));
  endsequence

  chk_insn_wait: assert property (@(posedge core_clk) disable iff (rst)
    (state_r == IAM_IDLE && !insn_done) |=> !irq_take_r)
    else $error("accept without an instruction boundary");
  chk_take_once: assert property (@(posedge core_clk) disable iff (rst)
    irq_take_r |=> !irq_take_r)
    else $error("accept strobe longer than one cycle");
  chk_push_capture: assert property (@(posedge core_clk) disable iff (rst)
    irq_take_r |-> s_capture)
    else $error("pushed state not captured at accept");
  chk_enable_gate: assert property (@(posedge core_clk) disable iff (rst)
    sel_found |-> req_enable[sel_idx])
    else $error("disabled request selected");
  chk_lvl1_first: assert property (@(posedge core_clk) disable iff (rst)
    (sel_found && allow_lvl1 && any_lvl1) |-> lvl1_map[sel_idx])
    else $error("level 0 request chosen over level 1");
  chk_tie_order: assert property (@(posedge core_clk) disable iff (rst)
    sel_found |-> !(|(live_used & below_sel & same_lvl)))
    else $error("tie not broken by default order");
  chk_lvl0_masked: assert property (@(posedge core_clk) disable iff (rst)
    (boundary && !cfg.scheme_sel && flags_in.global_mask && !any_lvl1 && !want_nmi) |=> !irq_take_r)
    else $error("level 0 request accepted under global mask");
  chk_lvl1_open: assert property (@(posedge core_clk) disable iff (rst)
    (boundary && !cfg.scheme_sel && !flags_in.second_mask && any_lvl1) |=> irq_take_r)
    else $error("level 1 request held although unmasked");
  chk_scheme1_open: assert property (@(posedge core_clk) disable iff (rst)
    (boundary && cfg.scheme_sel && !flags_in.global_mask && (|live_used)) |=> irq_take_r)
    else $error("request held with global mask clear");
  chk_scheme1_keep: assert property (@(posedge core_clk) disable iff (rst)
    (state_r == IAM_SET_MASK && cfg.scheme_sel) |=> flags_out_r.second_mask == $past(flags_in.second_mask))
    else $error("second mask changed in global mask scheme");
  chk_flag_pulse: assert property (@(posedge core_clk) disable iff (rst)
    flags_wr_r |=> !flags_wr_r)
    else $error("mask write strobe longer than one cycle");

  // nmi must be caught outside standby and never inside it
  chk_nmi_capture: assert property (@(posedge core_clk) disable iff (rst)
    (nmi_edge && !standby) |=> nmi_latch_r)
    else $error("nmi edge lost");
  chk_standby_hold: assert property (@(posedge core_clk) disable iff (rst)
    (standby && !nmi_latch_r) |=> !nmi_latch_r)
    else $error("nmi latched during standby");
  chk_vec_pulse: assert property (@(posedge core_clk) disable iff (rst)
    vec_valid_r |=> !vec_valid_r)
    else $error("vector strobe longer than one cycle");
endmodule : iam_accept

/* design/iam_pkg.sv */
package iam_pkg;
  // ---------------------------------------------------------------
  // source map
  // ---------------------------------------------------------------
  localparam int NUM_SRC = 30;          // maskable sources, default order index 0 = highest
  localparam int NUM_GRP = 16;          // priority level register bits (a: 8, b: 8)
  localparam logic [7:0] NMI_VECTOR = 8'h07;
  localparam logic [7:0] PRIO_A_RESET = 8'h00;
  localparam logic [7:0] PRIO_B_RESET = 8'h00;
  localparam logic [15:0] VEC_BASE = 16'h0000;
  localparam int VEC_SHIFT = 2;         // four bytes per vector entry
  // vector number of each maskable source, in default priority order
  localparam logic [7:0] SRC_VEC [NUM_SRC] = '{
    8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h14, 8'h18, 8'h19, 8'h1A, 8'h1C,
    8'h1D, 8'h1E, 8'h20, 8'h21, 8'h22, 8'h24, 8'h25, 8'h26, 8'h28, 8'h29,
    8'h2A, 8'h34, 8'h35, 8'h36, 8'h37, 8'h3C, 8'h3C, 8'h3C, 8'h3C, 8'h3C};
  // priority level bit index (0..15: a7..a0 -> 15..8, b7..b0 -> 7..0)
  localparam int SRC_GRP [NUM_SRC] = '{
    15, 14, 13, 13, 12, 11, 10, 10, 10, 9,
    9, 9, 8, 8, 8, 7, 7, 7, 6, 6,
    6, 3, 3, 3, 3, 1, 1, 1, 1, 1};
  localparam int SRC_USED = 26;         // entries from this index on are spare and never request

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic scheme_sel;   // mask_scheme_select
    logic [7:0] prio_a; // priority_level_reg_a
    logic [7:0] prio_b; // priority_level_reg_b
  } iam_cfg_t;

  typedef struct packed {
    logic global_mask;  // condition_code_reg interrupt mask
    logic second_mask;  // second_mask_flag
  } iam_flags_t;

  typedef enum logic [2:0] {
    IAM_IDLE, IAM_WAIT_INSN, IAM_PUSH, IAM_SET_MASK, IAM_VECTOR
  } iam_state_t;
endpackage : iam_pkg

/* design/iam_select.sv */
`timescale 1ns/100ps
module iam_select
  import iam_pkg::*;
(
  input wire logic [NUM_SRC-1:0] req,
  input wire logic [NUM_SRC-1:0] enable,
  input wire logic [NUM_GRP-1:0] prio_bits,
  input wire logic [NUM_SRC-1:0] allowed_lvl0,
  input wire logic allow_lvl1,
  input wire logic allow_lvl0,
  output logic found,
  output logic [4:0] idx
);
  // ---------------------------------------------------------------
  // qualify and split by level
  // ---------------------------------------------------------------
  wire logic [NUM_SRC-1:0] live;
  wire logic [NUM_SRC-1:0] hi;
  wire logic [NUM_SRC-1:0] lo;
  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_src
      // a disabled request never reaches the selector
      assign live[g] = req[g] & enable[g] & (g < SRC_USED);
      assign hi[g] = live[g] & prio_bits[SRC_GRP[g]] & allow_lvl1;
      assign lo[g] = live[g] & ~prio_bits[SRC_GRP[g]] & allow_lvl0 & allowed_lvl0[g];
    end
  endgenerate

  // ---------------------------------------------------------------
  // level 1 before level 0, then lowest index wins
  // ---------------------------------------------------------------
  wire logic [NUM_SRC-1:0] pick = (|hi) ? hi : lo;
  always_comb begin
    found = |pick;
    idx = 5'h00;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (pick[i]) begin
        idx = 5'(i);
      end
    end
  end
endmodule : iam_select

/* design/iam_vector.sv */
`timescale 1ns/100ps
module iam_vector
  import iam_pkg::*;
(
  input wire logic is_nmi,
  input wire logic [4:0] idx,
  output logic [7:0] vec_num,
  output logic [15:0] vec_addr
);
  // ---------------------------------------------------------------
  // vector number and table address
  // ---------------------------------------------------------------
  wire logic [7:0] src_num = SRC_VEC[idx];
  assign vec_num = is_nmi ? NMI_VECTOR : src_num;
  assign vec_addr = VEC_BASE + 16'({vec_num, 2'b00});
endmodule : iam_vector

/* sim/iam_core_model.sv */
`timescale 1ns/100ps
// ------------------------------------------
// core side: instruction boundaries and push
// ------------------------------------------
module iam_core_model
  import iam_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic push_req,
  input wire logic vec_valid,
  output logic insn_done,
  output logic push_done,
  output logic [15:0] program_counter,
  output logic [7:0] condition_code_reg
);
  logic [1:0] cnt_r;
  logic [3:0] wait_r;
  logic busy_r;

  // a boundary every fourth cycle; none while handling runs, so the
  // block never sees a second boundary before the vector is out
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_r <= 2'h0;
      wait_r <= 4'h0;
      busy_r <= 1'b0;
      insn_done <= 1'b0;
      push_done <= 1'b0;
      program_counter <= 16'h0100;
      condition_code_reg <= 8'h00;
    end else begin
      cnt_r <= cnt_r + 2'h1;
      busy_r <= (busy_r | push_req) & ~vec_valid;
      insn_done <= ~busy_r & ~push_req & (cnt_r == 2'h3);
      if (~busy_r & ~push_req & (cnt_r == 2'h3)) begin
        program_counter <= program_counter + 16'h0002;
        condition_code_reg <= condition_code_reg + 8'h01;
      end
      // stack push answered two cycles after push_req rises, or after a long stall
      wait_r <= push_req ? wait_r + 4'h1 : 4'h0;
      push_done <= push_req & (wait_r == (slow ? 4'h9 : 4'h1));
    end
  end
endmodule : iam_core_model

/* sim/test_iam_accept.sv */
`timescale 1ns/100ps
// ------------------------------------------
// directed bench for acceptance and masking
// ------------------------------------------
module test_iam_accept
  import iam_pkg::*;
;
  logic core_clk = 1'b0, rst = 1'b1, standby = 1'b0, nmi_pin = 1'b0, slow = 1'b0;
  logic [NUM_SRC-1:0] ext_req_pin = '0, mod_req = '0, req_enable = '1, pending;
  iam_cfg_t cfg = '0;
  iam_flags_t flags_in = '0, flags_out;
  logic insn_done, push_done, irq_take, push_req, flags_wr, vec_valid;
  logic [15:0] program_counter, push_pc, vec_addr, last_pc;
  logic [7:0] condition_code_reg, push_ccr, vec_num, last_ccr;
  int num_errors = 0, check_count = 0;

  always #4 core_clk = ~core_clk;

  iam_accept iam_accept_i (.core_clk, .rst, .standby, .nmi_pin, .ext_req_pin, .mod_req,
    .req_enable, .cfg, .flags_in, .insn_done, .program_counter, .condition_code_reg,
    .push_done, .irq_take, .push_req, .push_pc, .push_ccr, .flags_wr, .flags_out,
    .vec_valid, .vec_addr, .vec_num, .pending);
  iam_core_model iam_core_model_i (.core_clk, .rst, .slow, .push_req, .vec_valid,
    .insn_done, .push_done, .program_counter, .condition_code_reg);

  // state at the last boundary is what must be pushed
  always @(posedge core_clk) begin
    if (insn_done === 1'b1) begin
      last_pc <= program_counter;
      last_ccr <= condition_code_reg;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask : tick

  task automatic drive(input logic sch, input logic [1:0] fl, input logic [7:0] pb,
    input logic [NUM_SRC-1:0] en, input logic [NUM_SRC-1:0] mr, input logic [NUM_SRC-1:0] er);
    @(posedge core_clk);
    cfg <= '{scheme_sel: sch, prio_a: 8'h00, prio_b: pb};
    flags_in <= fl;
    req_enable <= en;
    mod_req <= mr;
    ext_req_pin <= er;
  endtask : drive

  // bounded waits; a missing answer fails the compare after the loop
  task automatic expect_take(input logic [7:0] vec, input logic [1:0] fl);
    int i;
    for (i = 0; i < 40 && irq_take !== 1'b1; i++) tick();
    check(irq_take, 1'b1);
    check(push_req, 1'b1);
    check({push_ccr, push_pc}, {last_ccr, last_pc});
    for (i = 0; i < 30 && flags_wr !== 1'b1; i++) tick();
    check({flags_wr, flags_out}, {1'b1, fl});
    tick();
    check({vec_valid, vec_num}, {1'b1, vec});
    check(vec_addr, {6'h00, vec, 2'h0});
  endtask : expect_take

  task automatic expect_none(input int n);
    logic seen = 1'b0;
    repeat (n) begin
      tick();
      seen |= (irq_take === 1'b1);
    end
    check(seen, 1'b0);
  endtask : expect_none

  // scenarios in order; each drive replaces the previous requests, and the nmi scenarios keep the last one pending
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) tick();
    drive(1'b1, 2'b00, 8'h00, '1, 30'h1, 30'h2);
    expect_take(8'h0C, 2'b10);
    check(pending[1], 1'b1);
    drive(1'b1, 2'b00, 8'h00, '1, 30'h0, 30'h2);
    expect_take(8'h0D, 2'b10);
    drive(1'b1, 2'b00, 8'h00, ~30'h1, 30'h3, 30'h0);
    expect_take(8'h0D, 2'b10);
    check(pending[0], 1'b0);
    drive(1'b0, 2'b00, 8'h02, '1, 30'h2000001, 30'h0);
    expect_take(8'h3C, 2'b11);
    drive(1'b0, 2'b10, 8'h02, '1, 30'h2000001, 30'h0);
    expect_take(8'h3C, 2'b11);
    drive(1'b0, 2'b10, 8'h02, '1, 30'h1, 30'h0);
    expect_none(30);
    drive(1'b0, 2'b11, 8'h02, '1, 30'h2000001, 30'h0);
    expect_none(30);
    drive(1'b0, 2'b00, 8'h02, '1, 30'h1, 30'h0);
    expect_take(8'h0C, 2'b11);
    drive(1'b1, 2'b10, 8'h02, '1, 30'h2000000, 30'h0);
    expect_none(30);
    // slow push plus a masked request still pending
    @(posedge core_clk);
    slow <= 1'b1;
    nmi_pin <= 1'b1;
    expect_take(8'h07, 2'b10);
    @(posedge core_clk);
    nmi_pin <= 1'b0;
    standby <= 1'b1;
    repeat (3) tick();
    @(posedge core_clk);
    nmi_pin <= 1'b1;
    expect_none(30);
    test_done();
  end

  // the run needs about 210 cycles
  initial begin
    repeat (5000) @(posedge core_clk);
    num_errors++;
    test_done();
  end
endmodule : test_iam_accept
